// File: common/mcd_pkg.sv
/*
  mcd_pkg: codes, field positions, rate enumeration and decoded-command
  record for the monitor command decoder.
  Assumes frames are already checked by the transport layer.
*/
package mcd_pkg;

  // frame layout
  localparam int CODE_W      = 11;
  localparam int HI_ZERO_MSB = 7;
  localparam int HI_ZERO_LSB = 3;

  // option field positions inside the 11-bit code
  localparam int RATE_MSB  = 8;
  localparam int RATE_LSB  = 7;
  localparam int SELF_MSB  = 6;
  localparam int SELF_LSB  = 5;
  localparam int DCH_BIT   = 4;
  localparam int ITEM_MSB  = 2;
  localparam int ITEM_LSB  = 0;
  localparam int CELL_MSB  = 2;
  localparam int CELL_LSB  = 0;

  // fixed codes
  localparam logic [10:0] CLEAR_CELL_CODE  = 11'h711;
  localparam logic [10:0] CLEAR_AUX_CODE   = 11'h712;
  localparam logic [10:0] CLEAR_STAT_CODE  = 11'h713;
  localparam logic [10:0] POLL_CODE        = 11'h714;
  localparam logic [10:0] MUX_DIAG_CODE    = 11'h715;
  localparam logic [10:0] LINK_WRITE_CODE  = 11'h721;
  localparam logic [10:0] LINK_READ_CODE   = 11'h722;
  localparam logic [10:0] LINK_START_CODE  = 11'h723;

  // pattern pieces for the conversion family
  localparam logic [1:0] CONV_TOP       = 2'h2;
  localparam logic [4:0] AUX_ST_LOW     = 5'h07;
  localparam logic [4:0] STAT_ST_LOW    = 5'h0F;
  localparam logic [3:0] STAT_MID       = 4'hD;
  localparam logic [3:0] STAT_RED_MID   = 4'h1;
  localparam logic [1:0] COMB_MID       = 2'h3;
  localparam logic [3:0] COMB_GPIO_LOW  = 4'hF;
  localparam logic [3:0] COMB_SUM_LOW   = 4'h7;
  localparam logic [2:0] ITEM_MAX       = 3'h4;
  localparam logic [2:0] CELL_ALL       = 3'h0;
  localparam logic [2:0] CELL_SET_MAX   = 3'h6;

  // cell set timing at the two extreme rates
  localparam int SET_FAST_US  = 203;
  localparam int SET_SLOW_MS  = 34;
  localparam int CLK_MHZ      = 100;
  localparam int SET_FAST_CYC = SET_FAST_US * CLK_MHZ;
  localparam int SET_SLOW_CYC = SET_SLOW_MS * 1000 * CLK_MHZ;

  // command identifiers, one-hot
  typedef enum logic [14:0] {
    MCD_NONE        = 15'h0000,
    MCD_AUX_ST      = 15'h0001,
    MCD_STAT        = 15'h0002,
    MCD_STAT_RED    = 15'h0004,
    MCD_STAT_ST     = 15'h0008,
    MCD_CELL_GPIO   = 15'h0010,
    MCD_CELL_SUM    = 15'h0020,
    MCD_CLR_CELL    = 15'h0040,
    MCD_CLR_AUX     = 15'h0080,
    MCD_CLR_STAT    = 15'h0100,
    MCD_POLL        = 15'h0200,
    MCD_MUX_DIAG    = 15'h0400,
    MCD_LINK_WR     = 15'h0800,
    MCD_LINK_RD     = 15'h1000,
    MCD_LINK_START  = 15'h2000
  } mcd_cmd_type;

  // eight conversion rates, one-hot
  typedef enum logic [7:0] {
    MCD_R27K  = 8'h01,
    MCD_R14K  = 8'h02,
    MCD_R7K   = 8'h04,
    MCD_R3K   = 8'h08,
    MCD_R2K   = 8'h10,
    MCD_R1K   = 8'h20,
    MCD_R422  = 8'h40,
    MCD_R26   = 8'h80
  } mcd_rate_type;

  // incoming frame
  typedef struct packed {
    logic [7:0] command_byte_hi;
    logic [7:0] command_byte_lo;
  } mcd_frame_type;

  // decoded result
  typedef struct packed {
    mcd_cmd_type  cmd;
    mcd_rate_type rate;
    logic [1:0]   self_test_sel;
    logic [2:0]   status_item_sel;
    logic         discharge_allow;
  } mcd_dec_type;

endpackage

// File: core/mcd_rate_pick.sv
/*
  mcd_rate_pick: maps the two-bit rate selector and bank option bit
  onto one of eight conversion rates. Pure combinational.
  Assumes the bank bit comes from stored configuration.
*/
`timescale 1ns/1ps
module mcd_rate_pick
  import mcd_pkg::*;
(
  // selector inputs
  input  wire logic [1:0]   conv_rate_sel_i,
  input  wire logic         rate_bank_opt_i,
  // chosen rate
  output mcd_rate_type      rate_o
);

  // bank 0 lists 27k,7k,26,422; bank 1 lists 14k,3k,2k,1k
  mcd_rate_type bank0_w;
  mcd_rate_type bank1_w;

  assign bank0_w = (conv_rate_sel_i == 2'h0) ? MCD_R422 :
                   (conv_rate_sel_i == 2'h1) ? MCD_R27K :
                   (conv_rate_sel_i == 2'h2) ? MCD_R7K  : MCD_R26;
  assign bank1_w = (conv_rate_sel_i == 2'h0) ? MCD_R1K  :
                   (conv_rate_sel_i == 2'h1) ? MCD_R14K :
                   (conv_rate_sel_i == 2'h2) ? MCD_R3K  : MCD_R2K;
  assign rate_o  = rate_bank_opt_i ? bank1_w : bank0_w;

endmodule // mcd_rate_pick

// File: core/mcd_cell_group.sv
/*
  mcd_cell_group: expands the three-bit cell group selector into an
  18-bit mask of the cells to convert.
  Assumes 18 cells; codes 7 give an empty mask.
*/
`timescale 1ns/1ps
module mcd_cell_group
  import mcd_pkg::*;
#(
  parameter int CELLS = 18
) (
  // selector
  input  wire logic [2:0]       cell_group_sel_i,
  // cells picked
  output logic [CELLS-1:0]      cell_mask_o
);

  // set n holds cells n, n+6, n+12 (1-based)
  for (genvar c = 0; c < CELLS; c++) begin : g_cell
    assign cell_mask_o[c] = (cell_group_sel_i == CELL_ALL) ||
        ({29'h0, cell_group_sel_i} == ((c % 6) + 1));
  end

endmodule // mcd_cell_group

// File: core/mcd_decoder.sv
/*
  mcd_decoder: decodes a checked two-byte command frame into one
  registered one-cycle command pulse with its option fields.
  Assumes frame_valid_i pulses once per frame whose error code passed.
*/
`timescale 1ns/1ps
// What this block does
// - A frame carries the 11-bit code in hi byte bits 2:0 and the lo byte, hi bits 7:3 zero, protected by an error code.
// - Top 10 with low bits 00111 is the aux self-test with rate in 8:7 and test pattern in 6:5.
// - Top 10 with bits 6:3 1101 is the status conversion with rate in 8:7 and item in 2:0.
// - Top 10 with bits 6:3 0001 is the redundant status conversion with the same fields.
// - Top 10 with low bits 01111 is the status self-test with rate and test pattern.
// - Top 10, 6:5 11, 3:0 1111 is the cells plus first two aux inputs conversion, bit 4 permitting discharge.
// - Top 10, 6:5 11, 3:0 0111 is the cells plus stack sum conversion with rate and discharge bit.
// - Three fixed codes clear the cell, aux and status result groups.
// - A fixed code polls conversion progress without starting one.
// - A fixed code starts the multiplexer diagnosis, which reports busy like a conversion.
// - Three fixed codes write, read and start the auxiliary link group.
// - Rate selector plus bank bit choose one of eight conversion rates.
// - Cell selector 0 means all cells, 1 to 6 one set of three cells six apart.
// - A status conversion with item 5 or 6 is ignored.
module mcd_decoder
  import mcd_pkg::*;
#(
  parameter int CELLS = 18
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // frame from transport
  input  wire logic             frame_valid_i,
  input  mcd_frame_type         frame_i,
  // configuration
  input  wire logic             rate_bank_opt_i,
  // progress of the conversion engine
  input  wire logic             engine_busy_i,
  // decoded command
  output logic                  cmd_valid_o,
  output mcd_dec_type           dec_o,
  output logic [CELLS-1:0]      cell_mask_o,
  output logic                  busy_o,
  output logic                  bad_frame_o
);

  // code extraction
  logic [10:0] code_w;
  logic        hi_ok_w;
  logic        top_w;

  assign code_w  = {frame_i.command_byte_hi[2:0],
                    frame_i.command_byte_lo};
  assign hi_ok_w = frame_i.command_byte_hi[HI_ZERO_MSB:HI_ZERO_LSB]
                   == 5'h00;
  assign top_w   = code_w[10:9] == CONV_TOP;

  // conversion family matches
  logic m_aux_st_w;
  logic m_stat_w;
  logic m_stat_red_w;
  logic m_stat_st_w;
  logic m_cell_gpio_w;
  logic m_cell_sum_w;
  logic item_ok_w;

  assign m_aux_st_w    = top_w && code_w[4:0] == AUX_ST_LOW;
  assign m_stat_w      = top_w && code_w[6:3] == STAT_MID;
  assign m_stat_red_w  = top_w && code_w[6:3] == STAT_RED_MID;
  assign m_stat_st_w   = top_w && code_w[4:0] == STAT_ST_LOW;
  assign m_cell_gpio_w = top_w && code_w[6:5] == COMB_MID
                         && code_w[3:0] == COMB_GPIO_LOW;
  assign m_cell_sum_w  = top_w && code_w[6:5] == COMB_MID
                         && code_w[3:0] == COMB_SUM_LOW;
  assign item_ok_w     = code_w[ITEM_MSB:ITEM_LSB] <= ITEM_MAX;

  // full command choice; combined patterns checked before the
  // self-test ones because 0111/1111 low bits overlap with bit 4 clear
  mcd_cmd_type cmd_w;

  assign cmd_w =
    !hi_ok_w                        ? MCD_NONE       :
    (code_w == CLEAR_CELL_CODE)     ? MCD_CLR_CELL   :
    (code_w == CLEAR_AUX_CODE)      ? MCD_CLR_AUX    :
    (code_w == CLEAR_STAT_CODE)     ? MCD_CLR_STAT   :
    (code_w == POLL_CODE)           ? MCD_POLL       :
    (code_w == MUX_DIAG_CODE)       ? MCD_MUX_DIAG   :
    (code_w == LINK_WRITE_CODE)     ? MCD_LINK_WR    :
    (code_w == LINK_READ_CODE)      ? MCD_LINK_RD    :
    (code_w == LINK_START_CODE)     ? MCD_LINK_START :
    m_cell_gpio_w                   ? MCD_CELL_GPIO  :
    m_cell_sum_w                    ? MCD_CELL_SUM   :
    m_aux_st_w                      ? MCD_AUX_ST     :
    m_stat_st_w                     ? MCD_STAT_ST    :
    (m_stat_w && item_ok_w)         ? MCD_STAT       :
    (m_stat_red_w && item_ok_w)     ? MCD_STAT_RED   :
    MCD_NONE;

  // option fields
  mcd_rate_type rate_w;
  logic [CELLS-1:0] mask_w;

  mcd_rate_pick u_rate (
    .conv_rate_sel_i (code_w[RATE_MSB:RATE_LSB]),
    .rate_bank_opt_i (rate_bank_opt_i),
    .rate_o          (rate_w)
  );

  mcd_cell_group #(.CELLS(CELLS)) u_cells (
    .cell_group_sel_i (code_w[CELL_MSB:CELL_LSB]),
    .cell_mask_o      (mask_w)
  );

  mcd_dec_type dec_next;
  logic        take_w;
  logic        starts_w;

  assign take_w   = frame_valid_i && cmd_w != MCD_NONE;
  assign dec_next = '{cmd:             cmd_w,
                      rate:            rate_w,
                      self_test_sel:   code_w[SELF_MSB:SELF_LSB],
                      status_item_sel: code_w[ITEM_MSB:ITEM_LSB],
                      discharge_allow: code_w[DCH_BIT]};
  // poll never starts anything; diag counts as a start
  assign starts_w = take_w && (cmd_w == MCD_MUX_DIAG ||
                    cmd_w == MCD_AUX_ST || cmd_w == MCD_STAT ||
                    cmd_w == MCD_STAT_RED || cmd_w == MCD_STAT_ST ||
                    cmd_w == MCD_CELL_GPIO ||
                    cmd_w == MCD_CELL_SUM);

  // output registers; dec holds the last taken command
  logic                  cmd_valid_reg;
  mcd_dec_type           dec_reg;
  logic [CELLS-1:0]      mask_reg;
  logic                  busy_reg;
  logic                  bad_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_valid_reg <= 1'b0;
      dec_reg       <= '0;
      mask_reg      <= '0;
      busy_reg      <= 1'b0;
      bad_reg       <= 1'b0;
    end else begin
      cmd_valid_reg <= take_w;
      bad_reg       <= frame_valid_i && !hi_ok_w;
      busy_reg      <= starts_w || engine_busy_i;
      if (take_w) begin
        dec_reg  <= dec_next;
        mask_reg <= mask_w;
      end
    end
  end

  assign cmd_valid_o = cmd_valid_reg;
  assign dec_o       = dec_reg;
  assign cell_mask_o = mask_reg;
  assign busy_o      = busy_reg;
  assign bad_frame_o = bad_reg;

  // checks; item 7 of a status code is the combined gpio code with
  // discharge off, so the refusal checks look at 5 and 6 only
  a_unknown_ignored: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && cmd_w == MCD_NONE |=> !cmd_valid_o)
    else $error("undefined code produced a command");

  a_dec_held: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    !take_w |=> $stable(dec_o) && $stable(cell_mask_o))
    else $error("decoded command changed without a taken frame");

  a_bad_item_drop: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_stat_w &&
    (code_w[ITEM_MSB:ITEM_LSB] == 3'h5 ||
     code_w[ITEM_MSB:ITEM_LSB] == 3'h6)
    |=> !cmd_valid_o)
    else $error("status item 5 or 6 was accepted");

  a_red_item_drop: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_stat_red_w &&
    (code_w[ITEM_MSB:ITEM_LSB] == 3'h5 ||
     code_w[ITEM_MSB:ITEM_LSB] == 3'h6)
    |=> !cmd_valid_o)
    else $error("redundant status item 5 or 6 was accepted");

  a_stat_item_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_stat_w &&
    code_w[ITEM_MSB:ITEM_LSB] <= ITEM_MAX
    |=> cmd_valid_o && dec_o.cmd == MCD_STAT &&
        dec_o.status_item_sel == $past(code_w[ITEM_MSB:ITEM_LSB]))
    else $error("status conversion not decoded");

  a_stat_red_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_stat_red_w &&
    code_w[ITEM_MSB:ITEM_LSB] <= ITEM_MAX
    |=> cmd_valid_o && dec_o.cmd == MCD_STAT_RED &&
        dec_o.status_item_sel == $past(code_w[ITEM_MSB:ITEM_LSB]))
    else $error("redundant status conversion not decoded");

  a_stat_selftest: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_stat_st_w && !m_cell_gpio_w
    |=> cmd_valid_o && dec_o.cmd == MCD_STAT_ST &&
        dec_o.self_test_sel == $past(code_w[SELF_MSB:SELF_LSB]))
    else $error("status self-test not decoded");

  a_clear_cell_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == CLEAR_CELL_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_CLR_CELL)
    else $error("clear cell code not decoded");

  a_clear_aux_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == CLEAR_AUX_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_CLR_AUX)
    else $error("clear aux code not decoded");

  a_clear_stat_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == CLEAR_STAT_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_CLR_STAT)
    else $error("clear status code not decoded");

  a_poll_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == POLL_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_POLL)
    else $error("poll code not decoded");

  a_poll_no_start: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == POLL_CODE && !engine_busy_i
    |=> !busy_o)
    else $error("poll started a conversion");

  a_diag_busy: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == MUX_DIAG_CODE |=> busy_o)
    else $error("diagnosis did not show busy");

  a_link_write_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == LINK_WRITE_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_LINK_WR)
    else $error("link write code not decoded");

  a_link_read_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == LINK_READ_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_LINK_RD)
    else $error("link read code not decoded");

  a_link_start_map: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && code_w == LINK_START_CODE
    |=> cmd_valid_o && dec_o.cmd == MCD_LINK_START)
    else $error("link start code not decoded");

  a_hi_zero_chk: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i &&
    frame_i.command_byte_hi[HI_ZERO_MSB:HI_ZERO_LSB] != 5'h00
    |=> bad_frame_o && !cmd_valid_o)
    else $error("frame with nonzero upper bits accepted");

  a_good_frame: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w |=> !bad_frame_o)
    else $error("clean frame flagged as bad");

  a_combined_dch: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_cell_gpio_w
    |=> cmd_valid_o && dec_o.cmd == MCD_CELL_GPIO
        && dec_o.discharge_allow == $past(code_w[DCH_BIT]))
    else $error("combined conversion or discharge flag wrong");

  a_sum_combined: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_cell_sum_w
    |=> dec_o.cmd == MCD_CELL_SUM)
    else $error("stack sum conversion not decoded");

  a_rate_bank: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    take_w && rate_bank_opt_i && code_w[RATE_MSB:RATE_LSB] == 2'h1
    |=> dec_o.rate == MCD_R14K)
    else $error("bank 1 selector 1 not 14 kHz");

  a_bank0_rate: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    take_w && !rate_bank_opt_i && code_w[RATE_MSB:RATE_LSB] == 2'h1
    |=> dec_o.rate == MCD_R27K)
    else $error("bank 0 selector 1 not 27 kHz");

  a_aux_selftest: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    frame_valid_i && hi_ok_w && m_aux_st_w && !m_cell_sum_w
    |=> dec_o.cmd == MCD_AUX_ST
        && dec_o.self_test_sel == $past(code_w[SELF_MSB:SELF_LSB]))
    else $error("aux self-test not decoded");

  a_mask_all: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    take_w && code_w[CELL_MSB:CELL_LSB] == CELL_ALL
    |=> &cell_mask_o)
    else $error("selector 0 did not pick every cell");

  a_mask_empty: assert property (@(posedge clock_i)
    disable iff (!nrst_i)
    take_w && code_w[CELL_MSB:CELL_LSB] == 3'h7
    |=> cell_mask_o == '0)
    else $error("selector 7 picked cells");

endmodule // mcd_decoder

// File: test/mcd_host_model.sv
/*
  mcd_host_model: host side of the command link, sends two-byte frames
  with a one-cycle valid strobe.
  Assumes the error code was checked upstream, so only framing is modelled.
*/
`timescale 1ns/1ps
module mcd_host_model
  import mcd_pkg::*;
(
  // clock
  input  wire logic      clock_i,
  // frame towards the decoder
  output logic           frame_valid_o,
  output mcd_frame_type  frame_o
);

  // idle bus at time zero
  initial begin
    frame_valid_o = 1'b0;
    frame_o       = '0;
  end

  // one frame, driven just after an edge and held for one cycle
  task automatic send_raw(input mcd_frame_type f);
    @(posedge clock_i);
    frame_valid_o <= 1'b1;
    frame_o       <= f;
    @(posedge clock_i);
    frame_valid_o <= 1'b0;
    frame_o       <= ~f; // stale data must not look valid
  endtask

  // code split over both bytes, top five bits forced low
  task automatic send_code(input logic [10:0] code);
    send_raw({5'h00, code[10:8], code[7:0]});
  endtask

endmodule // mcd_host_model

// File: test/tb.sv
/*
  tb: self-checking bench for the command decoder, cell mask included.
  Assumes the host model delivers frames on the bench clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb
  import mcd_pkg::*;
();
  logic          clock_i;
  logic          nrst_i;
  logic          frame_valid_i;
  mcd_frame_type frame_i;
  logic          rate_bank_opt_i;
  logic          engine_busy_i;
  logic          cmd_valid_o;
  mcd_dec_type   dec_o;
  logic [17:0]   cell_mask_o;
  logic          busy_o;
  logic          bad_frame_o;
  int            err_total;
  int            total_checks;

  // refused codes: status items 5 and 6, then undefined ones
  logic [10:0] bad_code [6] = '{11'h46D, 11'h46E, 11'h40D, 11'h40E,
                                11'h7FF, 11'h716};

  mcd_decoder u_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .frame_valid_i(frame_valid_i),
    .frame_i(frame_i), .rate_bank_opt_i(rate_bank_opt_i),
    .engine_busy_i(engine_busy_i), .cmd_valid_o(cmd_valid_o),
    .dec_o(dec_o), .cell_mask_o(cell_mask_o), .busy_o(busy_o),
    .bad_frame_o(bad_frame_o));
  mcd_host_model u_host (
    .clock_i(clock_i), .frame_valid_o(frame_valid_i), .frame_o(frame_i));

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // bank and selector together name one rate
  function automatic mcd_rate_type exp_rate(input logic [2:0] k);
    case (k)
      3'h0: return MCD_R422;
      3'h1: return MCD_R27K;
      3'h2: return MCD_R7K;
      3'h4: return MCD_R1K;
      3'h5: return MCD_R14K;
      3'h6: return MCD_R3K;
      3'h7: return MCD_R2K;
      default: return MCD_R26;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // send, expect a one-cycle pulse carrying the command
  task automatic send_chk(input logic [10:0] c, input mcd_cmd_type ec);
    u_host.send_code(c);
    #1;
    `CHK("taken", 1'b1, cmd_valid_o)
    `CHK("command", ec, dec_o.cmd)
    @(posedge clock_i);
    #1;
    `CHK("pulse end", 1'b0, cmd_valid_o)
  endtask

  task automatic conv_chk(input logic [10:0] c, input mcd_cmd_type ec,
                          input mcd_rate_type er);
    send_chk(c, ec);
    `CHK("rate", er, dec_o.rate)
  endtask

  // fixed codes worked out bit by bit
  task automatic t_fixed();
    send_chk(11'h711, MCD_CLR_CELL);
    send_chk(11'h712, MCD_CLR_AUX);
    send_chk(11'h713, MCD_CLR_STAT);
    send_chk(11'h714, MCD_POLL);
    send_chk(11'h715, MCD_MUX_DIAG);
    send_chk(11'h721, MCD_LINK_WR);
    send_chk(11'h722, MCD_LINK_RD);
    send_chk(11'h723, MCD_LINK_START);
  endtask

  // every conversion form under all eight rates
  task automatic t_conv();
    logic [1:0]   st;
    logic [2:0]   it;
    logic         dc;
    logic [1:0]   r;
    mcd_rate_type er;
    for (int k = 0; k < 8; k++) begin
      r  = k[1:0];
      st = 2'(k % 3);
      it = 3'(k % 5);
      dc = k[0];
      er = exp_rate(k[2:0]);
      @(posedge clock_i);
      rate_bank_opt_i <= k[2];
      conv_chk({2'h2, r, st, 5'h07}, MCD_AUX_ST, er);
      `CHK("test sel", st, dec_o.self_test_sel)
      conv_chk({2'h2, r, 4'hD, it}, MCD_STAT, er);
      `CHK("item", it, dec_o.status_item_sel)
      conv_chk({2'h2, r, 4'h1, it}, MCD_STAT_RED, er);
      `CHK("item", it, dec_o.status_item_sel)
      conv_chk({2'h2, r, st, 5'h0F}, MCD_STAT_ST, er);
      `CHK("test sel", st, dec_o.self_test_sel)
      conv_chk({2'h2, r, 2'h3, dc, 4'hF}, MCD_CELL_GPIO, er);
      `CHK("discharge", dc, dec_o.discharge_allow)
      conv_chk({2'h2, r, 2'h3, dc, 4'h7}, MCD_CELL_SUM, er);
      `CHK("discharge", dc, dec_o.discharge_allow)
    end
  endtask

  // refused frames leave the last command untouched
  task automatic t_refuse();
    mcd_dec_type held;
    held = dec_o;
    for (int i = 0; i < 6; i++) begin
      u_host.send_code(bad_code[i]);
      #1;
      `CHK("no pulse", 1'b0, cmd_valid_o)
      `CHK("held", held, dec_o)
    end
    u_host.send_raw(16'h0F11);
    #1;
    `CHK("bad frame", 1'b1, bad_frame_o)
    `CHK("no pulse", 1'b0, cmd_valid_o)
    `CHK("held", held, dec_o)
  endtask

  task automatic t_busy();
    u_host.send_code(11'h714);
    #1;
    `CHK("poll busy", 1'b0, busy_o)
    u_host.send_code(11'h715);
    #1;
    `CHK("diag busy", 1'b1, busy_o)
    @(posedge clock_i);
    engine_busy_i <= 1'b1;
    #1;
    `CHK("diag done", 1'b0, busy_o)
    @(posedge clock_i);
    engine_busy_i <= 1'b0;
    #1;
    `CHK("engine busy", 1'b1, busy_o)
  endtask

  // mid-run reset clears every output, then decoding resumes
  task automatic t_reset();
    u_host.send_code(11'h715);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    #1;
    `CHK("reset pulse", 1'b0, cmd_valid_o)
    `CHK("reset cmd", MCD_NONE, dec_o.cmd)
    `CHK("reset mask", 18'h0_0000, cell_mask_o)
    `CHK("reset busy", 1'b0, busy_o)
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    send_chk(11'h711, MCD_CLR_CELL);
  endtask

  // cell sets seen through the decoder; selector 6 only rides on
  // refused codes, so it cannot reach the mask from outside
  task automatic t_cells();
    logic [17:0] em;
    logic [10:0] c;
    for (int s = 0; s < 8; s++) begin
      em = (s == 0) ? '1 : (s == 7) ? '0 :
           (18'h1 << (s - 1)) | (18'h1 << (s + 5)) | (18'h1 << (s + 11));
      c  = (s == 7) ? 11'h407 : (s == 5) ? 11'h715 : {8'h8D, 3'(s)};
      if (s != 6) begin
        u_host.send_code(c);
        #1;
        `CHK("cell mask", em, cell_mask_o)
      end
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    err_total       = 0;
    total_checks    = 0;
    nrst_i          = 1'b0;
    rate_bank_opt_i = 1'b0;
    engine_busy_i   = 1'b0;
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_fixed();
    t_conv();
    t_refuse();
    t_busy();
    t_reset();
    t_cells();
    repeat (2) @(posedge clock_i);
    print_verdict();
  end

  // the whole run needs a few hundred cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    print_verdict();
  end

endmodule // tb
